// File: include/das_defs.svh
// Address map, field positions and reset values of the DMA address setup block.
// Assumes nothing of its surroundings; included by the package and design files.
`ifndef DAS_DEFS_SVH
`define DAS_DEFS_SVH

// Start and control register byte addresses per channel.
`define DAS_CH0_SRC_START 32'h4B00_0000
`define DAS_CH0_SRC_CTRL  32'h4B00_0004
`define DAS_CH0_DST_START 32'h4B00_0008
`define DAS_CH0_DST_CTRL  32'h4B00_000C
`define DAS_CH1_SRC_START 32'h4B00_0040
`define DAS_CH1_SRC_CTRL  32'h4B00_0044
`define DAS_CH1_DST_START 32'h4B00_0048
`define DAS_CH1_DST_CTRL  32'h4B00_004C
`define DAS_CH2_SRC_START 32'h4B00_0080
`define DAS_CH2_SRC_CTRL  32'h4B00_0084
`define DAS_CH2_DST_START 32'h4B00_0088
`define DAS_CH2_DST_CTRL  32'h4B00_008C
`define DAS_CH3_DST_START 32'h4B00_00B8
`define DAS_CH3_SRC_START 32'h4B00_00C0
`define DAS_CH3_SRC_CTRL  32'h4B00_00C4
`define DAS_CH3_DST_CTRL  32'h4B00_00CC

// Read-only live state, offsets added to each channel's source start address.
`define DAS_LIVE_SRC_OFS  32'h0000_0020
`define DAS_LIVE_DST_OFS  32'h0000_0024
`define DAS_LIVE_CNT_OFS  32'h0000_0028

// Field layout and reset value.
`define DAS_ADDR_W        31
`define DAS_CNT_W         20
`define DAS_SIDE_BIT      1
`define DAS_FIX_BIT       0
`define DAS_RST_VAL       32'h0000_0000

`endif

// File: include/das_pkg.sv
// Types shared by the DMA address setup block and its channel module.
// Assumes das_defs.svh is on the include path.
`include "das_defs.svh"

package das_pkg;

  // Channel sequencer states.
  typedef enum {das_st_idle, das_st_grant, das_st_run} das_state_t;

  // Per-channel inputs from the transfer engine, same clock domain.
  typedef struct packed {
    logic                   req;
    logic                   whole;
    logic [`DAS_CNT_W-1:0]  count;
    logic [1:0]             size;
    logic                   src_step;
    logic                   dst_step;
    logic                   unit_done;
  } das_chan_in_t;

  // Per-channel outputs towards the transfer engine.
  typedef struct packed {
    logic                   ack;
    logic                   src_periph;
    logic                   dst_periph;
    logic [`DAS_ADDR_W-1:0] src_ptr;
    logic [`DAS_ADDR_W-1:0] dst_ptr;
    logic [`DAS_CNT_W-1:0]  count;
  } das_chan_out_t;

endpackage

// File: design/das_channel.sv
// One DMA channel: acknowledge sequencer, transfer counter and live pointers.
// Assumes step and unit_done pulses come from the engine on clk_sys.
`timescale 1ns/10ps
`include "das_defs.svh"

module das_channel
(
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire das_pkg::das_chan_in_t  cin,
  input  wire logic [`DAS_ADDR_W-1:0] src_start,
  input  wire logic [`DAS_ADDR_W-1:0] dst_start,
  input  wire logic                   src_fixed,
  input  wire logic                   dst_fixed,
  output logic                        ack,
  output logic [`DAS_ADDR_W-1:0]      src_ptr,
  output logic [`DAS_ADDR_W-1:0]      dst_ptr,
  output logic [`DAS_CNT_W-1:0]       count
);

  // ==========================================================================
  // Sequencer
  das_pkg::das_state_t state;
  wire                 run     = (state == das_pkg::das_st_run);
  wire                 last    = (count == `DAS_CNT_W'(1)) || !cin.whole;
  wire [`DAS_ADDR_W-1:0] inc   = `DAS_ADDR_W'(1) << cin.size;

  // Ack rises with the counter load, before any beat is allowed to step.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state <= das_pkg::das_st_idle;
      ack   <= 1'b0;
      count <= '0;
    end
    else
    begin
      case (state)
        das_pkg::das_st_idle:
        begin
          if (cin.req)
          begin
            state <= das_pkg::das_st_grant;
            ack   <= 1'b1;
            count <= cin.count;
          end
        end
        das_pkg::das_st_grant: state <= das_pkg::das_st_run;
        das_pkg::das_st_run:
        begin
          if (cin.unit_done)
          begin
            count <= count - `DAS_CNT_W'(1);
            if (last)
            begin
              ack   <= 1'b0;
              state <= das_pkg::das_st_idle;
            end
          end
        end
        default: state <= das_pkg::das_st_idle;
      endcase
    end
  end

  // ==========================================================================
  // Pointers, side 0 is source and side 1 is destination
  logic [`DAS_ADDR_W-1:0] ptr    [2];
  logic [`DAS_ADDR_W-1:0] anchor [2];
  wire  [`DAS_ADDR_W-1:0] start  [2] = '{src_start, dst_start};
  wire                    fixed  [2] = '{src_fixed, dst_fixed};
  wire                    step   [2] = '{cin.src_step, cin.dst_step};

  // The anchor holds the value a fixed side returns to after each unit.
  for (genvar s = 0; s < 2; s++)
  begin : g_side
    wire [`DAS_ADDR_W-1:0] stepped = step[s] ? ptr[s] + inc : ptr[s];
    always_ff @(posedge clk_sys)
    begin
      if (srst)
      begin
        ptr[s]    <= '0;
        anchor[s] <= '0;
      end
      else if (ack && ptr[s] == '0)
      begin
        ptr[s]    <= start[s];
        anchor[s] <= start[s];
      end
      else if (run && cin.unit_done && fixed[s])
        ptr[s]    <= anchor[s];
      else if (run)
      begin
        ptr[s]    <= stepped;
        if (cin.unit_done)
          anchor[s] <= stepped;
      end
    end
  end

  assign src_ptr = ptr[0];
  assign dst_ptr = ptr[1];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_grant;
    state == das_pkg::das_st_idle && cin.req;
  endsequence

  grant_count_a: assert property (s_grant |=> ack && count == $past(cin.count))
    else $error("Counter not loaded with acknowledge.");
  src_load_a: assert property (ack && ptr[0] == '0 |=> ptr[0] == $past(start[0]))
    else $error("Source pointer not loaded from start.");
  dst_load_a: assert property (ack && ptr[1] == '0 |=> ptr[1] == $past(start[1]))
    else $error("Destination pointer not loaded from start.");
  src_fixed_a: assert property (run && cin.unit_done && fixed[0] && ptr[0] != '0
    |=> ptr[0] == $past(anchor[0]))
    else $error("Fixed source not restored after unit.");
endmodule

// File: design/das_addr_setup.sv
// DMA address setup: start addresses, stepping controls and live pointers of
// four channels, reached by software over a classic Wishbone slave port.
// Assumes the transfer engine drives chan_in on clk_sys and that the bus
// master holds each request until it sees ack.
//
// Functional notes
// - Source start loads the live source pointer when that is zero and ack high.
// - Destination start loads the live dest pointer when that is zero and ack high.
// - Source control bit 1 picks system bus (0) or peripheral bus (1).
// - Destination control bit 1 picks system bus (0) or peripheral bus (1).
// - Control bit 0 clear: address steps by data size after every transfer.
// - Control bit 0 set: address fixed; bursts step then return to start.
// - Accepted request raises ack and loads the counter before transfers begin.
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/10ps
`include "das_defs.svh"

module das_addr_setup
#(
  parameter int CHANNELS = 4
)
(
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [31:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  input  wire das_pkg::das_chan_in_t chan_in  [CHANNELS],
  output das_pkg::das_chan_out_t     chan_out [CHANNELS]
);

  // ==========================================================================
  // Address map
  // The map is irregular on the last channel, so each address is tabled
  // rather than computed from a stride.
  // Per channel, relative to its source start address:
  //   +0x00 source start, 31 bits.
  //   +0x04 source control, bits 1:0.
  //   +0x08 destination start, 31 bits.
  //   +0x0C destination control, bits 1:0.
  //   +0x20 live source pointer, read only.
  //   +0x24 live destination pointer, read only.
  //   +0x28 live transfer count, read only.
  // Channel 3 keeps its destination start at -0x08 instead.
  localparam logic [31:0] SS_ADR [4] = '{
    `DAS_CH0_SRC_START,
    `DAS_CH1_SRC_START,
    `DAS_CH2_SRC_START,
    `DAS_CH3_SRC_START};
  localparam logic [31:0] SC_ADR [4] = '{
    `DAS_CH0_SRC_CTRL,
    `DAS_CH1_SRC_CTRL,
    `DAS_CH2_SRC_CTRL,
    `DAS_CH3_SRC_CTRL};
  localparam logic [31:0] DS_ADR [4] = '{
    `DAS_CH0_DST_START,
    `DAS_CH1_DST_START,
    `DAS_CH2_DST_START,
    `DAS_CH3_DST_START};
  localparam logic [31:0] DC_ADR [4] = '{
    `DAS_CH0_DST_CTRL,
    `DAS_CH1_DST_CTRL,
    `DAS_CH2_DST_CTRL,
    `DAS_CH3_DST_CTRL};

  // ==========================================================================
  // Byte-lane merge
  // Applies the byte enables of a write to the old register value.
  function automatic logic [31:0] das_merge
  (
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction

  // ==========================================================================
  // Bus qualifiers
  // A request is taken only in the cycle before ack, so a held request is
  // served once and the master sees exactly one ack per access.
  wire req_ok = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_ok  = req_ok & wb_we_i;
  wire rd_ok  = req_ok & ~wb_we_i;

  // ==========================================================================
  // Software registers
  logic [`DAS_ADDR_W-1:0] src_start [CHANNELS];
  logic [`DAS_ADDR_W-1:0] dst_start [CHANNELS];
  logic [1:0]             src_ctrl  [CHANNELS];
  logic [1:0]             dst_ctrl  [CHANNELS];
  logic [31:0]            rd_ch     [CHANNELS];
  logic [`DAS_ADDR_W-1:0] c_src_ptr [CHANNELS];
  logic [`DAS_ADDR_W-1:0] c_dst_ptr [CHANNELS];
  logic [`DAS_CNT_W-1:0]  c_count   [CHANNELS];
  logic                   c_ack     [CHANNELS];

  for (genvar i = 0; i < CHANNELS; i++)
  begin : g_ch
    // Per-channel decode of the four writable and three live registers.
    wire hit_ss = (wb_adr_i == SS_ADR[i]);
    wire hit_sc = (wb_adr_i == SC_ADR[i]);
    wire hit_ds = (wb_adr_i == DS_ADR[i]);
    wire hit_dc = (wb_adr_i == DC_ADR[i]);
    wire hit_ls = (wb_adr_i == SS_ADR[i] + `DAS_LIVE_SRC_OFS);
    wire hit_ld = (wb_adr_i == SS_ADR[i] + `DAS_LIVE_DST_OFS);
    wire hit_lc = (wb_adr_i == SS_ADR[i] + `DAS_LIVE_CNT_OFS);

    // Merged write values; bit 31 of a start register does not exist.
    wire [31:0] m_ss = das_merge({1'b0, src_start[i]}, wb_dat_i, wb_sel_i);
    wire [31:0] m_ds = das_merge({1'b0, dst_start[i]}, wb_dat_i, wb_sel_i);
    wire [31:0] m_sc = das_merge({30'h0, src_ctrl[i]}, wb_dat_i, wb_sel_i);
    wire [31:0] m_dc = das_merge({30'h0, dst_ctrl[i]}, wb_dat_i, wb_sel_i);

    // Writes land on the edge that raises ack.
    always_ff @(posedge clk_sys)
    begin
      if (srst)
      begin
        src_start[i] <= `DAS_ADDR_W'(`DAS_RST_VAL);
        dst_start[i] <= `DAS_ADDR_W'(`DAS_RST_VAL);
        src_ctrl[i]  <= 2'(`DAS_RST_VAL);
        dst_ctrl[i]  <= 2'(`DAS_RST_VAL);
      end
      else
      begin
        if (wr_ok && hit_ss)
          src_start[i] <= m_ss[`DAS_ADDR_W-1:0];
        if (wr_ok && hit_ds)
          dst_start[i] <= m_ds[`DAS_ADDR_W-1:0];
        if (wr_ok && hit_sc)
          src_ctrl[i]  <= m_sc[1:0];
        if (wr_ok && hit_dc)
          dst_ctrl[i]  <= m_dc[1:0];
      end
    end

    // Read terms; unused upper bits read as zero.
    assign rd_ch[i] =
        ({32{hit_ss}} & {1'b0, src_start[i]})
      | ({32{hit_ds}} & {1'b0, dst_start[i]})
      | ({32{hit_sc}} & {30'h0, src_ctrl[i]})
      | ({32{hit_dc}} & {30'h0, dst_ctrl[i]})
      | ({32{hit_ls}} & {1'b0, c_src_ptr[i]})
      | ({32{hit_ld}} & {1'b0, c_dst_ptr[i]})
      | ({32{hit_lc}} & {12'h0, c_count[i]});

    // Channel sequencer and pointers.
    das_channel u_chan
    (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .cin       (chan_in[i]),
      .src_start (src_start[i]),
      .dst_start (dst_start[i]),
      .src_fixed (src_ctrl[i][`DAS_FIX_BIT]),
      .dst_fixed (dst_ctrl[i][`DAS_FIX_BIT]),
      .ack       (c_ack[i]),
      .src_ptr   (c_src_ptr[i]),
      .dst_ptr   (c_dst_ptr[i]),
      .count     (c_count[i])
    );

    // Every field below is a flip-flop in this module or the channel.
    assign chan_out[i].ack        = c_ack[i];
    assign chan_out[i].src_periph = src_ctrl[i][`DAS_SIDE_BIT];
    assign chan_out[i].dst_periph = dst_ctrl[i][`DAS_SIDE_BIT];
    assign chan_out[i].src_ptr    = c_src_ptr[i];
    assign chan_out[i].dst_ptr    = c_dst_ptr[i];
    assign chan_out[i].count      = c_count[i];
  end

  // ==========================================================================
  // Read data reduction
  // Decodes are one-hot, so an OR of the channel terms is the selected value.
  // An unmapped address yields zero and still acks, so software never hangs.
  logic [31:0] rd_all;
  always_comb
  begin
    rd_all = '0;
    for (int i = 0; i < CHANNELS; i++)
      rd_all = rd_all | rd_ch[i];
  end

  // ==========================================================================
  // Bus answer
  // One wait state: ack comes on the edge after the request is first seen
  // and drops on the next edge because req_ok is then false.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= req_ok;
      wb_dat_o <= rd_ok ? rd_all : '0;
    end
  end

  // ==========================================================================
  // Checks
  // These watch the register file, the bus answer and the stepping, counting
  // and ack release of channels 0 and 1; the channel module checks its own sequencing.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_ctrl_wr (logic [31:0] adr);
    wr_ok && wb_adr_i == adr && wb_sel_i[0];
  endsequence

  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  bus_ack_a: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Ack not a single pulse after request.");

  src_side_a: assert property (s_ctrl_wr(SC_ADR[0])
    |=> chan_out[0].src_periph == $past(wb_dat_i[`DAS_SIDE_BIT]))
    else $error("Source bus side not taken from control write.");

  dst_side_a: assert property (s_ctrl_wr(DC_ADR[0])
    |=> chan_out[0].dst_periph == $past(wb_dat_i[`DAS_SIDE_BIT]))
    else $error("Destination bus side not taken from control write.");

  // A read taken three edges after a write is the quickest that the idle cycle allows.
  start_rw_a: assert property (wr_ok && wb_adr_i == SS_ADR[1] && wb_sel_i == 4'hF
    ##3 rd_ok && wb_adr_i == SS_ADR[1]
    |=> wb_dat_o == {1'b0, $past(wb_dat_i[30:0], 4)})
    else $error("Start register read back differs from write.");

  // Reset itself is the trigger here, so the default disable must not apply.
  reset_clear_a: assert property (@(posedge clk_sys) disable iff (1'b0) srst |=>
    src_start[2] == '0 && dst_ctrl[2] == '0 && !wb_ack_o)
    else $error("Registers not cleared by reset.");

  inc_step_a: assert property (c_ack[0] && chan_in[0].src_step
    && !chan_in[0].unit_done && !src_ctrl[0][`DAS_FIX_BIT]
    && c_src_ptr[0] != '0 && $past(c_ack[0]) && u_state_run(0)
    |=> c_src_ptr[0] == $past(c_src_ptr[0])
        + (`DAS_ADDR_W'(1) << $past(chan_in[0].size)))
    else $error("Incrementing source did not step by data size.");

  // Helper for the step check: channel 0 is in its transfer phase.
  function automatic logic u_state_run(input int unused);
    return g_ch[0].u_chan.state == das_pkg::das_st_run;
  endfunction

  ack_drop_a: assert property (c_ack[1] && !chan_in[1].whole
    && chan_in[1].unit_done && u_state_run1()
    |=> !c_ack[1])
    else $error("Single service ack not released after unit.");

  // Helper for the release check on channel 1.
  function automatic logic u_state_run1();
    return g_ch[1].u_chan.state == das_pkg::das_st_run;
  endfunction

  // Outside a read answer the data lines rest at zero, so stale values never leak.
  rd_idle_a: assert property (!rd_ok |=> wb_dat_o == 32'h0000_0000)
    else $error("Read data not zero outside a read answer.");

  dst_step_a: assert property (c_ack[1] && chan_in[1].dst_step && !chan_in[1].unit_done
    && !dst_ctrl[1][`DAS_FIX_BIT] && c_dst_ptr[1] != '0 && u_state_run1()
    |=> c_dst_ptr[1] == $past(c_dst_ptr[1]) + (`DAS_ADDR_W'(1) << $past(chan_in[1].size)))
    else $error("Incrementing destination did not step by data size.");

  // Whole service keeps ack through every unit but the last and counts each one.
  whole_hold_a: assert property (c_ack[0] && chan_in[0].whole && chan_in[0].unit_done
    && c_count[0] > `DAS_CNT_W'(1) && u_state_run(0)
    |=> c_ack[0] && c_count[0] == $past(c_count[0]) - `DAS_CNT_W'(1))
    else $error("Whole service released ack or miscounted a unit.");

  // A fixed side steps through a burst of four, then returns to where it began.
  // The opening cycle must be quiet, so only the first unit of a service is seen.
  sequence s_dst_quiet;
    u_state_run(0) && dst_ctrl[0][`DAS_FIX_BIT] && c_dst_ptr[0] != '0
    && !chan_in[0].dst_step && !chan_in[0].unit_done;
  endsequence

  sequence s_dst_burst;
    s_dst_quiet ##1 chan_in[0].dst_step [*4] ##1 chan_in[0].unit_done && !chan_in[0].dst_step;
  endsequence

  dst_burst_a: assert property (s_dst_burst |=> c_dst_ptr[0] == $past(c_dst_ptr[0], 6))
    else $error("Fixed destination not restored after burst.");

endmodule

// File: verification/das_engine_model.sv
// Behavioural transfer engine that drives one channel's request and beat pulses.
// Assumes the channel answers on clk_sys and holds ack until its last unit ends.
`timescale 1ns/10ps

module das_engine_model
(
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic             go,
  input  wire logic             whole,
  input  wire logic [19:0]      count,
  input  wire logic [1:0]       size,
  input  wire logic [2:0]       beats,
  input  wire logic             ack,
  output das_pkg::das_chan_in_t cin,
  output logic                  busy
);
  // ==========================================================================
  // Service sequence
  int units;

  // One service per go: request, wait for ack, then units of beats and an end pulse.
  // Beats start two edges after ack is seen, so the channel is already running.
  initial
  begin
    cin = '0;
    busy = 1'b0;
    forever
    begin
      @(posedge clk_sys);
      if (go === 1'b1 && srst === 1'b0)
      begin
        busy <= 1'b1;
        cin.whole <= whole;
        cin.count <= count;
        cin.size <= size;
        cin.req <= 1'b1;
        do @(posedge clk_sys); while (ack !== 1'b1);
        cin.req <= 1'b0; // Dropped at once so the idle channel is not asked again.
        units = whole ? int'(count) : 1;
        repeat (2) @(posedge clk_sys);
        repeat (units)
        begin
          // Steps stay high through all beats of a unit, so no edge sees them written twice.
          cin.src_step <= 1'b1;
          cin.dst_step <= 1'b1;
          repeat (beats) @(posedge clk_sys);
          cin.src_step <= 1'b0;
          cin.dst_step <= 1'b0;
          cin.unit_done <= 1'b1;
          @(posedge clk_sys);
          cin.unit_done <= 1'b0;
        end
        @(posedge clk_sys);
        busy <= 1'b0;
      end
    end
  end
endmodule

// File: verification/das_addr_setup_test.sv
// Self-checking bench for the DMA address setup block.
// Assumes one engine model per channel and a classic Wishbone master in tasks.
`timescale 1ns/10ps
`include "das_defs.svh"

module das_addr_setup_test;
  // ==========================================================================
  // Channel set-up table: control bit 1 picks the bus, bit 0 fixes the address.
  localparam logic [1:0]  sctl  [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
  localparam logic [1:0]  dctl  [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
  localparam logic [1:0]  size  [4] = '{2'h2, 2'h0, 2'h1, 2'h2};
  localparam logic [2:0]  beats [4] = '{3'h4, 3'h1, 3'h4, 3'h4};
  localparam logic        whole [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  localparam logic [19:0] cnt   [4] = '{20'h3, 20'h5, 20'h2, 20'h1};

  logic                   clk_sys;
  logic                   srst;
  logic                   wb_cyc_i;
  logic                   wb_stb_i;
  logic                   wb_we_i;
  logic [31:0]            wb_adr_i;
  logic [3:0]             wb_sel_i;
  logic [31:0]            wb_dat_i;
  wire  [31:0]            wb_dat_o;
  wire                    wb_ack_o;
  wire das_pkg::das_chan_in_t  chan_in  [4];
  wire das_pkg::das_chan_out_t chan_out [4];
  logic [3:0]             go;
  wire  [3:0]             busy;
  int                     failures;
  int                     compares;
  int                     cycles;

  das_addr_setup #(.CHANNELS(4)) i_dut (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_in(chan_in), .chan_out(chan_out));

  for (genvar g = 0; g < 4; g++)
  begin : g_eng
    das_engine_model i_eng (.clk_sys(clk_sys), .srst(srst), .go(go[g]), .whole(whole[g]), .count(cnt[g]),
      .size(size[g]), .beats(beats[g]), .ack(chan_out[g].ack), .cin(chan_in[g]), .busy(busy[g]));
  end

  // ==========================================================================
  // Clock, hang guard and helpers.
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // The whole run needs a few hundred cycles; the ceiling leaves ample margin.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Channel 3 has its destination start out of the regular stride.
  function automatic logic [31:0] reg_adr(input int c, input int k);
    if (c == 3 && k == 2)
      return 32'h4B00_00B8;
    return 32'h4B00_0000 + 32'(c * 64 + k * 4);
  endfunction

  function automatic logic [31:0] pat(input int c, input int k);
    return 32'hFFFF_FFFF - 32'(c * 4 + k) * 32'h0101_0101;
  endfunction

  function automatic logic [31:0] src_st(input int c);
    return 32'(c + 1) * 32'h0000_1000;
  endfunction

  function automatic logic [31:0] dst_st(input int c);
    return 32'h0100_0000 + 32'(c) * 32'h0000_0100;
  endfunction

  // A fixed side ends each unit back at its start; an incrementing side moves on.
  function automatic logic [31:0] exp_ptr(input logic [31:0] st, input logic [1:0] ctl, input int c,
                                          input int runs);
    int units;
    units = whole[c] ? int'(cnt[c]) : 1;
    if (ctl[0])
      return st;
    return st + 32'(runs * units * int'(beats[c]) << size[c]);
  endfunction

  // The request is held until ack is sampled high, then released for a cycle.
  task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                         input logic [3:0] sel, output logic [31:0] rd);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] unused;
    wb_xfer(1'b1, adr, dat, sel, unused);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] adr, input logic [31:0] exp);
    logic [31:0] v;
    wb_xfer(1'b0, adr, 32'h0000_0000, 4'hF, v);
    check(what, v, exp);
  endtask

  task automatic run_chan(input int c);
    @(posedge clk_sys);
    go[c] <= 1'b1;
    @(posedge clk_sys);
    go[c] <= 1'b0;
    do @(posedge clk_sys); while (chan_out[c].ack !== 1'b1);
    check("loaded count", 32'(chan_out[c].count), 32'(cnt[c]));
    do @(posedge clk_sys); while (busy[c] !== 1'b0);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic test_reset();
    for (int c = 0; c < 4; c++)
      for (int k = 0; k < 4; k++)
        rd_chk("reset value", reg_adr(c, k), 32'h0000_0000);
  endtask

  // Start registers keep 31 bits, control registers two; a lane-0 write merges.
  task automatic test_reg_rw();
    for (int c = 0; c < 4; c++)
      for (int k = 0; k < 4; k++)
        wr(reg_adr(c, k), pat(c, k), 4'hF);
    for (int c = 0; c < 4; c++)
      for (int k = 0; k < 4; k++)
        rd_chk("read back", reg_adr(c, k), pat(c, k) & ((k % 2) ? 32'h3 : 32'h7FFF_FFFF));
    wr(reg_adr(0, 0), 32'h0000_0000, 4'h1);
    rd_chk("lane merge", reg_adr(0, 0), pat(0, 0) & 32'h7FFF_FF00);
    wr(32'h4B00_0030, 32'hFFFF_FFFF, 4'hF);
    rd_chk("unmapped", 32'h4B00_0030, 32'h0000_0000);
    wr(reg_adr(1, 0) + `DAS_LIVE_SRC_OFS, 32'hFFFF_FFFF, 4'hF);
    rd_chk("live read only", reg_adr(1, 0) + `DAS_LIVE_SRC_OFS, 32'h0000_0000);
    wr(reg_adr(1, 0), 32'hFEDC_BA98, 4'hF);
    rd_chk("write then read", reg_adr(1, 0), 32'h7EDC_BA98);
  endtask

  task automatic test_channels();
    for (int c = 0; c < 4; c++)
    begin
      wr(reg_adr(c, 0), src_st(c), 4'hF);
      wr(reg_adr(c, 1), {30'h0, sctl[c]}, 4'hF);
      wr(reg_adr(c, 2), dst_st(c), 4'hF);
      wr(reg_adr(c, 3), {30'h0, dctl[c]}, 4'hF);
      run_chan(c);
      check("ack released", 32'(chan_out[c].ack), 32'h0);
      check("end count", 32'(chan_out[c].count), whole[c] ? 32'h0 : 32'(cnt[c] - 20'h1));
      check("src ptr", 32'(chan_out[c].src_ptr), exp_ptr(src_st(c), sctl[c], c, 1));
      check("dst ptr", 32'(chan_out[c].dst_ptr), exp_ptr(dst_st(c), dctl[c], c, 1));
      check("src bus", 32'(chan_out[c].src_periph), 32'(sctl[c][1]));
      check("dst bus", 32'(chan_out[c].dst_periph), 32'(dctl[c][1]));
      rd_chk("live src", reg_adr(c, 0) + `DAS_LIVE_SRC_OFS, exp_ptr(src_st(c), sctl[c], c, 1));
      rd_chk("live dst", reg_adr(c, 0) + `DAS_LIVE_DST_OFS, exp_ptr(dst_st(c), dctl[c], c, 1));
    end
  endtask

  // Nonzero pointers must not take new start values on a second service.
  task automatic test_no_reload();
    wr(reg_adr(0, 0), 32'h0055_0000, 4'hF);
    wr(reg_adr(0, 2), 32'h0066_0000, 4'hF);
    run_chan(0);
    check("src kept", 32'(chan_out[0].src_ptr), exp_ptr(src_st(0), sctl[0], 0, 2));
    check("dst kept", 32'(chan_out[0].dst_ptr), exp_ptr(dst_st(0), dctl[0], 0, 2));
    rd_chk("start held", reg_adr(0, 0), 32'h0055_0000);
  endtask

  // A reset after the last service clears the sampled registers and live state of channels 0, 1 and 2.
  task automatic test_mid_reset();
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    check("reset src ptr", 32'(chan_out[0].src_ptr), 32'h0000_0000);
    check("reset count", 32'(chan_out[1].count), 32'h0000_0000);
    rd_chk("reset start", reg_adr(0, 0), 32'h0000_0000);
    rd_chk("reset control", reg_adr(2, 1), 32'h0000_0000);
  endtask

  // Inputs settle at time zero; reset is held for sixteen edges.
  initial
  begin
    srst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 32'h0000_0000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    go = 4'h0;
    failures = 0;
    compares = 0;
    cycles = 0;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    test_reset();
    test_reg_rw();
    test_channels();
    test_no_reload();
    test_mid_reset();
    tally_and_finish();
  end
endmodule
